// ---- inc/monitor_regs_pkg.sv ----
package monitor_regs_pkg;

  // register addresses
  localparam logic [7:0]  CONTROL_ADDR     = 8'h01;
  localparam logic [7:0]  PREV_RANGE_ADDR  = 8'h10;
  localparam logic [7:0]  ALERT_FLAGS_ADDR = 8'h11;
  localparam logic [7:0]  SETTINGS_ADDR    = 8'h12;
  localparam logic [7:0]  RANGE_ADDR       = 8'h13;

  // reset values
  localparam logic [15:0] CONTROL_RESET    = 16'h2520;
  localparam logic [7:0]  SETTINGS_RESET   = 8'h10;
  localparam logic [3:0]  RANGE_RESET      = 4'h0;

  // control field positions
  localparam int          AUTO_LSB         = 0;
  localparam int          ACC_SRC_LSB      = 2;
  localparam int          AVG_LSB          = 5;
  localparam int          PIN0_MODE_LSB    = 8;
  localparam int          PIN1_MODE_LSB    = 10;
  localparam int          MODE_LSB         = 12;

  // settings bit positions
  localparam int          PIN1_BIT         = 7;
  localparam int          PIN0_BIT         = 6;
  localparam int          ANY_ALERT_BIT    = 5;
  localparam int          POR_BIT          = 4;
  localparam int          TIMEOUT_BIT      = 3;
  localparam int          BYTE_COUNT_BIT   = 2;
  localparam int          FAST_RATE_BIT    = 0;

  // alert flag layout
  localparam logic [15:0] FLAG_MASK        = 16'h3ffc;
  localparam logic [15:0] LIMIT_MASK       = 16'h3ff0;
  localparam int          SUM_FULL_BIT     = 3;
  localparam int          TALLY_FULL_BIT   = 2;

  // field encodings
  localparam logic [1:0]  AUTO_OFF         = 2'h0;
  localparam logic [1:0]  AUTO_CLEAR       = 2'h1;
  localparam logic [1:0]  AUTO_KEEP        = 2'h2;
  localparam logic [1:0]  AUTO_RSVD        = 2'h3;
  localparam logic [1:0]  SRC_RSVD         = 2'h3;
  localparam logic [1:0]  RANGE_RSVD       = 2'h3;
  localparam logic [1:0]  PIN_ALERT        = 2'h0;
  localparam logic [1:0]  PIN_OUTPUT       = 2'h2;
  localparam logic [3:0]  SS_AVG_MODE      = 4'h7;
  localparam logic [1:0]  REFRESH_FULL     = 2'h0;
  localparam logic [1:0]  REFRESH_KEEP     = 2'h1;
  localparam logic [1:0]  REFRESH_GENERAL  = 2'h2;

  // averaging code to sample count, reserved codes fall back to eight
  function automatic logic [7:0] avg_count(input logic [2:0] code);
    case (code)
      3'h0:    avg_count = 8'h04;
      3'h1:    avg_count = 8'h08;
      3'h2:    avg_count = 8'h10;
      3'h3:    avg_count = 8'h20;
      3'h5:    avg_count = 8'h40;
      3'h7:    avg_count = 8'h80;
      default: avg_count = 8'h08;
    endcase
  endfunction : avg_count

endpackage : monitor_regs_pkg

// ---- rtl/level_sync.sv ----
module level_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             clk,   // sampling clock
  input  wire logic             reset, // synchronous, active high
  input  wire logic [WIDTH-1:0] din,   // asynchronous levels
  output logic      [WIDTH-1:0] dout   // synchronised levels
);

  logic [WIDTH-1:0] stage;

  // two flops, first one read only by the second
  always_ff @(posedge clk) begin
    if (reset) begin
      stage <= '0;
      dout  <= '0;
    end else begin
      stage <= din;
      dout  <= stage;
    end
  end

endmodule : level_sync

// ---- rtl/monitor_refresh_alert_regs.sv ----
module monitor_refresh_alert_regs
  import monitor_regs_pkg::*;
(
  input  wire logic        CLK_SYS,           // system clock, 20 MHz
  input  wire logic        RESET,             // synchronous reset, active high
  input  wire logic [7:0]  REG_ADDR,          // register address from bus front end
  input  wire logic        REG_WR,            // write strobe, one cycle
  input  wire logic [15:0] REG_WDATA,         // write data
  input  wire logic        REG_RD,            // read strobe, one cycle
  output logic      [15:0] REG_RDATA,         // read data, next cycle
  input  wire logic        REFRESH_REQ,       // host refresh command pulse
  input  wire logic [1:0]  REFRESH_KIND,      // full, keep totals, general call
  input  wire logic        CONV_DONE,         // conversion cycle complete pulse
  input  wire logic [15:0] LIMIT_ALERTS,      // limit conditions, bits 13:4
  input  wire logic [15:0] ALERT_ENABLE,      // alert enable bits
  input  wire logic        SUM_OVERFLOW,      // accumulator overflowed
  input  wire logic        SUM_OVER_LIMIT,    // accumulator past fullness threshold
  input  wire logic        TALLY_OVERFLOW,    // sample tally overflowed
  input  wire logic        TALLY_OVER_LIMIT,  // sample tally past fullness threshold
  input  wire logic        ADDR_PIN_ZERO_IN,  // address pin zero level
  output logic             ADDR_PIN_ZERO_OUT, // address pin zero drive value
  output logic             ADDR_PIN_ZERO_OE_N,// low while pulling pin zero low
  input  wire logic        ADDR_PIN_ONE_IN,   // address pin one level
  output logic             ADDR_PIN_ONE_OUT,  // address pin one drive value
  output logic             ADDR_PIN_ONE_OE_N, // low while pulling pin one low
  output logic             REFRESH_PULSE,     // results move to readable domain
  output logic             ACC_CLEAR,         // clear accumulator and tally
  output logic             CONFIG_LOAD,       // pending settings activated
  output logic      [1:0]  ACC_SOURCE,        // active accumulator source select
  output logic      [1:0]  SENSE_RANGE,       // active sense range select
  output logic      [1:0]  BUS_RANGE,         // active bus range select
  output logic      [3:0]  SAMPLE_MODE,       // active sample mode
  output logic             TIMEOUT_EN,        // bus timeout enable
  output logic             BYTE_COUNT_EN,     // block read byte count enable
  output logic             FAST_BUS_RATE,     // fast bus rate enable
  output logic             ANY_ALERT          // any alert flag set
);

  logic [15:0] pending_control;
  logic [15:0] active_control;
  logic [3:0]  pending_range;
  logic [3:0]  active_range;
  logic [3:0]  prev_range;
  logic [15:0] alert_flags;
  logic        read_seen;
  logic [7:0]  tally;
  logic        pin1_data;
  logic        pin0_data;
  logic        por_flag;
  logic        timeout_en;
  logic        byte_count_en;
  logic        fast_rate;
  logic [1:0]  pin_level;
  logic [15:0] next_pending_control;
  logic [15:0] next_active_control;
  logic [3:0]  next_pending_range;
  logic [3:0]  next_active_range;
  logic [3:0]  next_prev_range;
  logic [15:0] next_alert_flags;
  logic        next_read_seen;
  logic [7:0]  next_tally;
  logic        next_pin1_data;
  logic        next_pin0_data;
  logic        next_por_flag;
  logic        next_timeout_en;
  logic        next_byte_count_en;
  logic        next_fast_rate;
  logic [15:0] next_rdata;
  logic        next_refresh;
  logic        next_clear;
  logic        next_load;
  logic        next_pin0_oe_n;
  logic        next_pin1_oe_n;
  logic [15:0] cond;
  logic [15:0] settings_view;
  logic [1:0]  auto_mode;
  logic [1:0]  pin0_mode;
  logic [1:0]  pin1_mode;
  logic        auto_on;
  logic        ss_avg;
  logic        tally_done;
  logic        manual_ok;
  logic        auto_fire;
  logic        wr_control;
  logic        wr_range;
  logic        wr_settings;

  // address pins pass two flops before use
  level_sync #(
    .WIDTH (2)
  ) u_pin_sync (
    .clk   (CLK_SYS),
    .reset (RESET),
    .din   ({ADDR_PIN_ONE_IN, ADDR_PIN_ZERO_IN}),
    .dout  (pin_level)
  );

  // decoded fields and strobes
  assign auto_mode   = pending_control[AUTO_LSB +: 2];
  assign pin0_mode   = active_control[PIN0_MODE_LSB +: 2];
  assign pin1_mode   = active_control[PIN1_MODE_LSB +: 2];
  assign auto_on     = (auto_mode != AUTO_OFF);
  assign ss_avg      = (active_control[MODE_LSB +: 4] == SS_AVG_MODE);
  assign tally_done  = !ss_avg || (tally >= avg_count(active_control[AVG_LSB +: 3]) - 8'h01);
  assign manual_ok   = REFRESH_REQ && !auto_on;
  assign auto_fire   = CONV_DONE && auto_on && tally_done;
  assign wr_control  = REG_WR && (REG_ADDR == CONTROL_ADDR);
  assign wr_range    = REG_WR && (REG_ADDR == RANGE_ADDR);
  assign wr_settings = REG_WR && (REG_ADDR == SETTINGS_ADDR);

  // enabled conditions seen at this completion
  always_comb begin
    cond                 = LIMIT_ALERTS & LIMIT_MASK;
    cond[SUM_FULL_BIT]   = SUM_OVERFLOW || SUM_OVER_LIMIT;
    cond[TALLY_FULL_BIT] = TALLY_OVERFLOW || TALLY_OVER_LIMIT;
    cond                 = cond & ALERT_ENABLE & FLAG_MASK;
  end

  // settings register as read back
  always_comb begin
    settings_view                 = 16'h0000;
    settings_view[PIN1_BIT]       = (pin1_mode == PIN_OUTPUT) ? pin1_data : pin_level[1];
    settings_view[PIN0_BIT]       = (pin0_mode == PIN_OUTPUT) ? pin0_data : pin_level[0];
    settings_view[ANY_ALERT_BIT]  = ANY_ALERT;
    settings_view[POR_BIT]        = por_flag;
    settings_view[TIMEOUT_BIT]    = timeout_en;
    settings_view[BYTE_COUNT_BIT] = byte_count_en;
    settings_view[FAST_RATE_BIT]  = fast_rate;
  end

  // next values for control, range and refresh sequencing
  always_comb begin
    next_pending_control = pending_control;
    next_pending_range   = pending_range;
    next_active_control  = active_control;
    next_active_range    = active_range;
    next_prev_range      = prev_range;
    next_tally           = tally;
    next_refresh         = manual_ok || auto_fire;
    next_clear           = 1'b0;
    next_load            = manual_ok;
    if (wr_control) begin
      next_pending_control = REG_WDATA;
      if (REG_WDATA[ACC_SRC_LSB +: 2] == SRC_RSVD) begin
        next_pending_control[ACC_SRC_LSB +: 2] = pending_control[ACC_SRC_LSB +: 2];
      end
      if (REG_WDATA[AUTO_LSB +: 2] == AUTO_RSVD) begin
        next_pending_control[AUTO_LSB +: 2] = pending_control[AUTO_LSB +: 2];
      end
    end
    if (wr_range) begin
      if (REG_WDATA[3:2] != RANGE_RSVD) begin
        next_pending_range[3:2] = REG_WDATA[3:2];
      end
      if (REG_WDATA[1:0] != RANGE_RSVD) begin
        next_pending_range[1:0] = REG_WDATA[1:0];
      end
    end
    if (CONV_DONE && auto_on) begin
      next_tally = tally_done ? 8'h00 : tally + 8'h01;
    end else if (!auto_on) begin
      next_tally = 8'h00;
    end
    if (manual_ok) begin
      next_clear          = (REFRESH_KIND != REFRESH_KEEP);
      next_active_control = pending_control;
      next_active_range   = pending_range;
    end else if (auto_fire) begin
      next_clear = (auto_mode == AUTO_CLEAR);
    end
    if (manual_ok || auto_fire) begin
      next_prev_range = active_range;
    end
  end

  // next values for alert flags and settings
  always_comb begin
    next_alert_flags   = alert_flags;
    next_read_seen     = read_seen || (REG_RD && (REG_ADDR == ALERT_FLAGS_ADDR));
    next_pin1_data     = pin1_data;
    next_pin0_data     = pin0_data;
    next_por_flag      = por_flag;
    next_timeout_en    = timeout_en;
    next_byte_count_en = byte_count_en;
    next_fast_rate     = fast_rate;
    if (CONV_DONE) begin
      next_alert_flags = (read_seen ? 16'h0000 : alert_flags) | cond;
      next_read_seen   = REG_RD && (REG_ADDR == ALERT_FLAGS_ADDR);
    end
    if (wr_settings) begin
      if (pin1_mode == PIN_OUTPUT) begin
        next_pin1_data = REG_WDATA[PIN1_BIT];
      end
      if (pin0_mode == PIN_OUTPUT) begin
        next_pin0_data = REG_WDATA[PIN0_BIT];
      end
      next_por_flag      = por_flag && REG_WDATA[POR_BIT];
      next_timeout_en    = REG_WDATA[TIMEOUT_BIT];
      next_byte_count_en = REG_WDATA[BYTE_COUNT_BIT];
      next_fast_rate     = REG_WDATA[FAST_RATE_BIT];
    end
    next_pin0_oe_n = !(((pin0_mode == PIN_OUTPUT) && !pin0_data) || ((pin0_mode == PIN_ALERT) && ANY_ALERT));
    next_pin1_oe_n = !(((pin1_mode == PIN_OUTPUT) && !pin1_data) || ((pin1_mode == PIN_ALERT) && ANY_ALERT));
  end

  // read data mux, unmapped addresses answer zero
  always_comb begin
    next_rdata = REG_RDATA;
    if (REG_RD) begin
      if (REG_ADDR == CONTROL_ADDR) begin
        next_rdata = pending_control;
      end else if (REG_ADDR == PREV_RANGE_ADDR) begin
        next_rdata = {12'h000, prev_range};
      end else if (REG_ADDR == ALERT_FLAGS_ADDR) begin
        next_rdata = alert_flags;
      end else if (REG_ADDR == SETTINGS_ADDR) begin
        next_rdata = settings_view;
      end else if (REG_ADDR == RANGE_ADDR) begin
        next_rdata = {12'h000, pending_range};
      end else begin
        next_rdata = 16'h0000;
      end
    end
  end

  // state registers
  always_ff @(posedge CLK_SYS) begin
    if (RESET) begin
      pending_control    <= CONTROL_RESET;
      active_control     <= CONTROL_RESET;
      pending_range      <= RANGE_RESET;
      active_range       <= RANGE_RESET;
      prev_range         <= RANGE_RESET;
      alert_flags        <= 16'h0000;
      read_seen          <= 1'b0;
      tally              <= 8'h00;
      pin1_data          <= SETTINGS_RESET[PIN1_BIT];
      pin0_data          <= SETTINGS_RESET[PIN0_BIT];
      por_flag           <= SETTINGS_RESET[POR_BIT];
      timeout_en         <= SETTINGS_RESET[TIMEOUT_BIT];
      byte_count_en      <= SETTINGS_RESET[BYTE_COUNT_BIT];
      fast_rate          <= SETTINGS_RESET[FAST_RATE_BIT];
      REG_RDATA          <= 16'h0000;
      REFRESH_PULSE      <= 1'b0;
      ACC_CLEAR          <= 1'b0;
      CONFIG_LOAD        <= 1'b0;
      ANY_ALERT          <= 1'b0;
      ADDR_PIN_ZERO_OUT  <= 1'b0;
      ADDR_PIN_ONE_OUT   <= 1'b0;
      ADDR_PIN_ZERO_OE_N <= 1'b1;
      ADDR_PIN_ONE_OE_N  <= 1'b1;
    end else begin
      pending_control    <= next_pending_control;
      active_control     <= next_active_control;
      pending_range      <= next_pending_range;
      active_range       <= next_active_range;
      prev_range         <= next_prev_range;
      alert_flags        <= next_alert_flags;
      read_seen          <= next_read_seen;
      tally              <= next_tally;
      pin1_data          <= next_pin1_data;
      pin0_data          <= next_pin0_data;
      por_flag           <= next_por_flag;
      timeout_en         <= next_timeout_en;
      byte_count_en      <= next_byte_count_en;
      fast_rate          <= next_fast_rate;
      REG_RDATA          <= next_rdata;
      REFRESH_PULSE      <= next_refresh;
      ACC_CLEAR          <= next_clear;
      CONFIG_LOAD        <= next_load;
      ANY_ALERT          <= (next_alert_flags != 16'h0000);
      ADDR_PIN_ZERO_OUT  <= 1'b0;
      ADDR_PIN_ONE_OUT   <= 1'b0;
      ADDR_PIN_ZERO_OE_N <= next_pin0_oe_n;
      ADDR_PIN_ONE_OE_N  <= next_pin1_oe_n;
    end
  end

  // active settings seen by the converter, bus options taken straight from the settings register
  assign ACC_SOURCE    = active_control[ACC_SRC_LSB +: 2];
  assign SAMPLE_MODE   = active_control[MODE_LSB +: 4];
  assign SENSE_RANGE   = active_range[3:2];
  assign BUS_RANGE     = active_range[1:0];
  assign TIMEOUT_EN    = timeout_en;
  assign BYTE_COUNT_EN = byte_count_en;
  assign FAST_BUS_RATE = fast_rate;

  // checks on refresh, flags and settings
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (RESET);

  chk_manual_ignored: assert property (REFRESH_REQ && auto_on && !CONV_DONE |=> !REFRESH_PULSE && !CONFIG_LOAD)
    else $error("host refresh taken while auto-refresh on");
  chk_manual_taken: assert property (REFRESH_REQ && !auto_on |=> REFRESH_PULSE && CONFIG_LOAD)
    else $error("host refresh not executed");
  chk_auto_clear: assert property (CONV_DONE && auto_mode == AUTO_CLEAR && !ss_avg |=> REFRESH_PULSE && ACC_CLEAR)
    else $error("auto clearing refresh missing");
  chk_auto_keep: assert property (CONV_DONE && auto_mode == AUTO_KEEP && !ss_avg |=> REFRESH_PULSE && !ACC_CLEAR)
    else $error("auto keep refresh wrong");
  chk_avg_defer: assert property (CONV_DONE && auto_on && ss_avg && !tally_done |=> !REFRESH_PULSE)
    else $error("auto refresh before averaging count");
  chk_prev_copy: assert property (REFRESH_PULSE |-> prev_range == $past(active_range))
    else $error("previous range not copied on refresh");
  chk_cfg_frozen: assert property (auto_on |=> active_control == $past(active_control))
    else $error("settings activated during auto-refresh");
  chk_flag_clear: assert property (read_seen && CONV_DONE |=> alert_flags == $past(cond))
    else $error("read flags not reloaded at completion");
  chk_flag_accum: assert property (CONV_DONE && !read_seen |=> alert_flags == ($past(alert_flags) | $past(cond)))
    else $error("flags not set at completion");
  chk_flag_hold: assert property (!CONV_DONE |=> $stable(alert_flags))
    else $error("flags changed without completion");
  chk_flag_layout: assert property ((alert_flags & ~FLAG_MASK) == 16'h0000)
    else $error("unimplemented flag bit set");
  chk_any_alert: assert property (ANY_ALERT == (alert_flags != 16'h0000))
    else $error("summary alert bit mismatch");
  chk_pin_guard: assert property (wr_settings && pin0_mode != PIN_OUTPUT |=> pin0_data == $past(pin0_data))
    else $error("pin data written outside output mode");
  chk_por_sticky: assert property (!por_flag |=> !por_flag)
    else $error("reset flag set again without reset");

endmodule : monitor_refresh_alert_regs

// ---- dv/addr_pin_pullup.sv ----
module addr_pin_pullup (
  input  wire logic drive0,  // pin zero drive value
  input  wire logic hold0_n, // low while pin zero is pulled
  input  wire logic drive1,  // pin one drive value
  input  wire logic hold1_n, // low while pin one is pulled
  output logic      pin0,    // resolved pin zero level
  output logic      pin1     // resolved pin one level
);
  timeunit 1ns;
  timeprecision 1ps;
  // open-drain pins, external pull-up wins when released
  assign pin0 = hold0_n ? 1'b1 : drive0;
  assign pin1 = hold1_n ? 1'b1 : drive1;
endmodule : addr_pin_pullup

// ---- dv/testbench.sv ----
`define CHK(nm, e, g) begin tests_run++; if ((g) !== (e)) begin err_total++; $display("BAD %s exp %h got %h", nm, e, g); end end
module testbench
  import monitor_regs_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk_sys = 1'b0, reset = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, refresh_req = 1'b0, conv_done = 1'b0;
  logic        sum_ovf = 1'b0, sum_lim = 1'b0, tal_ovf = 1'b0, tal_lim = 1'b0;
  logic [7:0]  reg_addr = 8'h00;
  logic [15:0] reg_wdata = 16'h0000, limit_alerts = 16'h0000, alert_enable = 16'h0000, reg_rdata;
  logic [1:0]  refresh_kind = 2'h0, acc_src, sense_rng, bus_rng;
  logic [3:0]  smode;
  logic        p0_out, p0_oe_n, p1_out, p1_oe_n, pin0, pin1, rf_pulse, acc_clear, cfg_load, tmo, bcnt, fast, any_alert;
  int          err_total = 0, tests_run = 0, n;

  // system clock, 50 ns period
  always #25 clk_sys = ~clk_sys;

  monitor_refresh_alert_regs dut_u (.CLK_SYS(clk_sys), .RESET(reset), .REG_ADDR(reg_addr), .REG_WR(reg_wr),
    .REG_WDATA(reg_wdata), .REG_RD(reg_rd), .REG_RDATA(reg_rdata), .REFRESH_REQ(refresh_req),
    .REFRESH_KIND(refresh_kind), .CONV_DONE(conv_done), .LIMIT_ALERTS(limit_alerts), .ALERT_ENABLE(alert_enable),
    .SUM_OVERFLOW(sum_ovf), .SUM_OVER_LIMIT(sum_lim), .TALLY_OVERFLOW(tal_ovf), .TALLY_OVER_LIMIT(tal_lim),
    .ADDR_PIN_ZERO_IN(pin0), .ADDR_PIN_ZERO_OUT(p0_out), .ADDR_PIN_ZERO_OE_N(p0_oe_n), .ADDR_PIN_ONE_IN(pin1),
    .ADDR_PIN_ONE_OUT(p1_out), .ADDR_PIN_ONE_OE_N(p1_oe_n), .REFRESH_PULSE(rf_pulse), .ACC_CLEAR(acc_clear),
    .CONFIG_LOAD(cfg_load), .ACC_SOURCE(acc_src), .SENSE_RANGE(sense_rng), .BUS_RANGE(bus_rng),
    .SAMPLE_MODE(smode), .TIMEOUT_EN(tmo), .BYTE_COUNT_EN(bcnt), .FAST_BUS_RATE(fast), .ANY_ALERT(any_alert));

  addr_pin_pullup pins_u (.drive0(p0_out), .hold0_n(p0_oe_n), .drive1(p1_out), .hold1_n(p1_oe_n),
    .pin0(pin0), .pin1(pin1));

  // one register write, strobe for one edge, then an idle edge
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(posedge clk_sys); #1;
    reg_wr = 1'b0;
    @(posedge clk_sys); #1;
  endtask : wr

  // one register read compared against an expected value
  task automatic chk_rd(input string nm, input logic [7:0] a, input logic [15:0] e);
    reg_addr = a;
    reg_rd = 1'b1;
    @(posedge clk_sys); #1;
    reg_rd = 1'b0;
    `CHK(nm, e, reg_rdata)
    @(posedge clk_sys); #1;
  endtask : chk_rd

  // refresh request or conversion pulse, checks pulse, clear and load
  task automatic step(input string nm, input logic req, input logic cd, input logic [2:0] e);
    refresh_req = req;
    conv_done = cd;
    @(posedge clk_sys); #1;
    refresh_req = 1'b0;
    conv_done = 1'b0;
    `CHK(nm, e, {rf_pulse, acc_clear, cfg_load})
    @(posedge clk_sys); #1;
  endtask : step

  // verdict and end of run
  task automatic complete_run;
    $display("checks %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : complete_run

  // main sequence
  initial begin
    repeat (2) @(posedge clk_sys);
    #1 reset = 1'b0;
    repeat (3) @(posedge clk_sys);
    #1;
    chk_rd("settings", SETTINGS_ADDR, 16'h00d0);
    chk_rd("prev range", PREV_RANGE_ADDR, 16'h0000);
    chk_rd("flags", ALERT_FLAGS_ADDR, 16'h0000);
    chk_rd("unmapped", 8'h20, 16'h0000);
    wr(SETTINGS_ADDR, 16'h0010);
    chk_rd("pin input", SETTINGS_ADDR, 16'h00d0);
    $display("test reset done");
    wr(RANGE_ADDR, 16'h00f5);
    chk_rd("range", RANGE_ADDR, 16'h0005);
    step("manual", 1'b1, 1'b0, 3'b111);
    chk_rd("prev range", PREV_RANGE_ADDR, 16'h0000);
    `CHK("active range", 4'h5, {sense_rng, bus_rng})
    wr(RANGE_ADDR, 16'h000b);
    chk_rd("range rsvd", RANGE_ADDR, 16'h0009);
    refresh_kind = 2'h1;
    step("keep", 1'b1, 1'b0, 3'b101);
    chk_rd("prev range", PREV_RANGE_ADDR, 16'h0005);
    `CHK("active range", 4'h9, {sense_rng, bus_rng})
    $display("test range done");
    refresh_kind = 2'h0;
    wr(CONTROL_ADDR, 16'h2524);
    step("manual", 1'b1, 1'b0, 3'b111);
    `CHK("source", 2'h1, acc_src)
    wr(CONTROL_ADDR, 16'h252d);
    chk_rd("source rsvd", CONTROL_ADDR, 16'h2525);
    step("req ignored", 1'b1, 1'b0, 3'b000);
    step("auto clear", 1'b0, 1'b1, 3'b110);
    wr(CONTROL_ADDR, 16'h2526);
    step("auto keep", 1'b0, 1'b1, 3'b100);
    wr(CONTROL_ADDR, 16'h2520);
    step("auto off", 1'b0, 1'b1, 3'b000);
    wr(CONTROL_ADDR, 16'h2523);
    chk_rd("auto rsvd", CONTROL_ADDR, 16'h2520);
    `CHK("source", 2'h1, acc_src)
    refresh_kind = 2'h2;
    wr(CONTROL_ADDR, 16'h7a20);
    step("general", 1'b1, 1'b0, 3'b111);
    `CHK("mode", 4'h7, smode)
    wr(CONTROL_ADDR, 16'h7a22);
    n = 0;
    for (int i = 0; i < 16; i++) begin
      conv_done = 1'b1;
      @(posedge clk_sys); #1;
      conv_done = 1'b0;
      n += int'(rf_pulse === 1'b1);
      @(posedge clk_sys); #1;
    end
    `CHK("avg refreshes", 2, n)
    wr(CONTROL_ADDR, 16'h7a20);
    $display("test refresh done");
    wr(SETTINGS_ADDR, 16'h0000);
    `CHK("pins low", 4'h0, {p1_oe_n, p0_oe_n, pin1, pin0})
    wr(SETTINGS_ADDR, 16'h00df);
    chk_rd("settings", SETTINGS_ADDR, 16'h00cd);
    `CHK("immediate", 3'b111, {tmo, bcnt, fast})
    `CHK("pins free", 4'hf, {p1_oe_n, p0_oe_n, pin1, pin0})
    $display("test settings done");
    wr(CONTROL_ADDR, 16'h7020);
    step("alert pins", 1'b1, 1'b0, 3'b111);
    limit_alerts = 16'h0200;
    step("no enable", 1'b0, 1'b1, 3'b000);
    chk_rd("flags", ALERT_FLAGS_ADDR, 16'h0000);
    alert_enable = 16'hffff;
    limit_alerts = 16'hffff;
    sum_lim = 1'b1;
    tal_ovf = 1'b1;
    step("set", 1'b0, 1'b1, 3'b000);
    `CHK("any alert", 1'b1, any_alert)
    `CHK("alert pins low", 2'b00, {p1_oe_n, p0_oe_n})
    chk_rd("flags all", ALERT_FLAGS_ADDR, 16'h3ffc);
    chk_rd("alert pin level", SETTINGS_ADDR, 16'h002d);
    limit_alerts = 16'h0200;
    sum_lim = 1'b0;
    tal_ovf = 1'b0;
    step("held", 1'b0, 1'b1, 3'b000);
    limit_alerts = 16'h0000;
    step("unread", 1'b0, 1'b1, 3'b000);
    chk_rd("flags kept", ALERT_FLAGS_ADDR, 16'h0200);
    step("clear", 1'b0, 1'b1, 3'b000);
    `CHK("any alert", 1'b0, any_alert)
    `CHK("alert pins free", 2'b11, {p1_oe_n, p0_oe_n})
    chk_rd("flags clear", ALERT_FLAGS_ADDR, 16'h0000);
    $display("test alerts done");
    // second reset brings the reset flag back and clears the previous range
    reset = 1'b1;
    repeat (2) @(posedge clk_sys);
    #1 reset = 1'b0;
    repeat (3) @(posedge clk_sys);
    #1;
    chk_rd("por again", SETTINGS_ADDR, 16'h00d0);
    chk_rd("prev cleared", PREV_RANGE_ADDR, 16'h0000);
    $display("test reset again done");
    complete_run();
  end
endmodule : testbench
